// >>> src/srx_pkg.sv
// How it works
// - Lock output high while unlocked, low locked
// - Power-down with outputs on: low outputs, unlock high
// - Power-down parks clock output at edge-select level
// - Output-disable floats data, sync, enable and clock
// - Edge-select picks launch edge of clock output
package srx_pkg;

  // Recovered pixel word carried from the link side
  typedef struct packed {
    logic        de;    // Data enable
    logic [2:0]  sync;  // Sync bits
    logic [17:0] data;  // Pixel data
  } srx_word_t;

  localparam int WORD_W = $bits(srx_word_t);

  // APB register byte offsets
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK   = 12'h008;
  localparam logic [11:0] ADDR_STATE  = 12'h00c;

  // Control register fields
  localparam int CTRL_SOFT_DIS = 0;  // Software output disable
  localparam int CTRL_DE_CHK   = 1;  // Data-enable timing check on
  localparam logic [1:0] CTRL_RST = 2'h2;

  // Status and mask fields (same layout)
  localparam int EV_LOCK_LOST = 0;
  localparam int EV_LOCK_GAIN = 1;
  localparam int EV_HI_SHORT  = 2;
  localparam int EV_HI_LONG   = 3;
  localparam int EV_LO_SHORT  = 4;
  localparam int EV_BAD_MODE  = 5;
  localparam int EV_W         = 6;
  localparam logic [5:0] STATUS_RST = 6'h00;
  localparam logic [5:0] MASK_RST   = 6'h00;

  // State register fields
  localparam int ST_LOCK = 0;
  localparam int ST_PDN  = 1;
  localparam int ST_DIS  = 2;
  localparam int ST_EDGE = 3;
  localparam int ST_MODE = 4;  // Two bits

  // Operation mode strap codes
  localparam logic [1:0] MODE_NORMAL    = 2'h0;
  localparam logic [1:0] MODE_HANDSHAKE = 2'h1;

  // Data-enable timing in pixel clock periods
  localparam int DE_HI_MIN_PER  = 2;
  localparam int DE_LO_MIN_NORM = 50;
  localparam int DE_LO_MIN_HS   = 2;

  // Longest data-enable high time, converted at the system clock rate
  localparam int CLK_MHZ        = 250;
  localparam int DE_HI_MAX_US   = 80;
  localparam int DE_MAX_CYC_DEF = DE_HI_MAX_US * CLK_MHZ;

endpackage : srx_pkg

// >>> src/srx_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of unrelated levels
module srx_sync2 #(
  parameter int W = 1  // Bundle width
)(
  input  wire logic         pclk,     // System clock
  input  wire logic         presetn,  // Async reset, active low
  input  wire logic [W-1:0] d,        // Asynchronous inputs
  output logic      [W-1:0] q         // Synchronised outputs
);

  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // Two stages, each bit independent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : srx_sync2

// >>> src/srx_output_ctrl.sv
`timescale 1ns/1ps
// Output side of the serial pixel receiver
module srx_output_ctrl
  import srx_pkg::*;
#(
  parameter int DE_MAX_CYCLES = DE_MAX_CYC_DEF,  // Longest enable high
  parameter int CNT_W         = 16                // Cycle counter width
)(
  input  wire logic        pclk,                // System clock
  input  wire logic        presetn,             // Async reset, low
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB enable
  input  wire logic        pwrite,              // APB direction
  input  wire logic [11:0] paddr,               // APB address
  input  wire logic [31:0] pwdata,              // APB write data
  output logic      [31:0] prdata,              // APB read data
  output logic             pready,              // APB ready
  output logic             pslverr,             // APB error
  input  wire logic        link_clk_in,         // Recovered link clock
  input  srx_word_t        link_word_in,        // Recovered word
  input  wire logic        pll_locked,          // Receive PLL locked
  input  wire logic        power_down_n,        // Power-down, low
  input  wire logic        output_disable,      // Output float, high
  input  wire logic        edge_select,         // High: rising edge
  input  wire logic [1:0]  op_mode_select,      // Mode straps
  output logic [17:0]      pixel_data_out,      // Pixel data
  output logic [2:0]       sync_bits_out,       // Sync bits
  output logic             de_out,              // Data enable
  output logic             recovered_clock_out, // Pixel clock out
  output logic             pix_oe,              // Enable, all four
  output logic             link_unlocked_n,     // High while unlocked
  output logic             irq                  // Level interrupt
);

  // Synchronised inputs
  logic [WORD_W+6:0] raw_in;   // Bundle into the synchroniser
  logic [WORD_W+6:0] sync_in;  // Bundle out of it
  logic              clk_s;    // Link clock level
  srx_word_t         word_s;   // Link word
  logic              lock_s;   // PLL locked
  logic              pdn_s;    // Power-down, low active
  logic              dis_s;    // Output disable pin
  logic              edge_s;   // Edge select
  logic [1:0]        mode_s;   // Mode straps

  assign raw_in = {link_clk_in, link_word_in, pll_locked, power_down_n,
                   output_disable, edge_select, op_mode_select};

  srx_sync2 #(.W(WORD_W + 7)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (raw_in),
    .q       (sync_in)
  );

  assign {clk_s, word_s, lock_s, pdn_s, dis_s, edge_s, mode_s} = sync_in;

  // Registers
  logic [1:0]       ctrl_q;     // Control
  logic [EV_W-1:0]  status_q;   // Sticky events
  logic [EV_W-1:0]  status_d;   // Next events
  logic [EV_W-1:0]  mask_q;     // Interrupt mask
  logic             clk_d_q;    // Delayed link clock for edges
  logic             lock_d_q;   // Delayed lock for edges
  srx_word_t        cap_q;      // Word caught at rising link edge
  logic             bad_d_q;    // Delayed bad-mode flag
  logic             de_prev_q;  // Enable level at previous edge
  logic [7:0]       hi_per_q;   // Periods with enable high
  logic [7:0]       lo_per_q;   // Periods with enable low
  logic [CNT_W-1:0] hi_cyc_q;   // System cycles with enable high

  // Decode and selection
  logic             rise_ev;    // Link clock rose
  logic             fall_ev;    // Link clock fell
  logic             off_q;      // Outputs floated
  logic             pd_act;     // Power-down, outputs on or off
  logic             launch;     // Launch edge for outputs
  logic             bad_mode;   // Unsupported strap code
  logic             hs_mode;    // Handshake mode strapped
  logic             chk_on;     // Enable check live
  logic             de_rise;    // Enable went high
  logic             de_fall;    // Enable went low
  logic [7:0]       lo_min;     // Least low period for mode
  logic [EV_W-1:0]  ev;         // Events this cycle
  logic             acc;        // APB access phase
  logic             done;       // APB transfer completes
  logic             wr_done;    // Completed write
  logic             rd_done;    // Completed read
  logic             hit;        // Mapped address
  logic [31:0]      rd_mux;     // Read data selection

  assign rise_ev  = clk_s & ~clk_d_q;
  assign fall_ev  = ~clk_s & clk_d_q;
  assign off_q    = dis_s | ctrl_q[CTRL_SOFT_DIS];
  assign pd_act   = ~pdn_s;
  assign launch   = edge_s ? rise_ev : fall_ev;
  assign hs_mode  = (mode_s == MODE_HANDSHAKE);
  assign bad_mode = (mode_s != MODE_NORMAL) && !hs_mode;
  assign chk_on   = ctrl_q[CTRL_DE_CHK] & lock_s & pdn_s;
  assign de_rise  = rise_ev & word_s.de & ~de_prev_q;
  assign de_fall  = rise_ev & ~word_s.de & de_prev_q;
  assign lo_min   = hs_mode ? 8'(DE_LO_MIN_HS) : 8'(DE_LO_MIN_NORM);

  // Event sources
  assign ev[EV_LOCK_LOST] = lock_d_q & ~lock_s;
  assign ev[EV_LOCK_GAIN] = ~lock_d_q & lock_s;
  assign ev[EV_HI_SHORT]  = chk_on & de_fall
                            & (hi_per_q < 8'(DE_HI_MIN_PER));
  assign ev[EV_HI_LONG]   = chk_on & !hs_mode & de_prev_q
                            & (hi_cyc_q == CNT_W'(DE_MAX_CYCLES));
  assign ev[EV_LO_SHORT]  = chk_on & de_rise & (lo_per_q < lo_min);
  assign ev[EV_BAD_MODE]  = bad_mode & ~bad_d_q;

  // APB decode
  assign acc     = psel & penable;
  assign done    = acc & pready;
  assign wr_done = done & pwrite & hit;
  assign rd_done = done & ~pwrite & hit;
  assign hit     = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_MASK) || (paddr == ADDR_STATE);
  assign rd_mux  = (paddr == ADDR_CTRL)   ? {30'h0, ctrl_q} :
                   (paddr == ADDR_STATUS) ? {26'h0, status_q} :
                   (paddr == ADDR_MASK)   ? {26'h0, mask_q} :
                   (paddr == ADDR_STATE)  ? {26'h0, mode_s, edge_s,
                                             dis_s, pdn_s, lock_s} :
                   32'h0;

  // Set wins over the read clear; only bits that the read returned are
  // cleared, so an event landing while the read is in flight survives
  assign status_d = (status_q & ~((rd_done && paddr == ADDR_STATUS)
                                  ? prdata[EV_W-1:0] : {EV_W{1'b0}})) | ev;

  // APB answer: one wait state, then ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else if (wr_done && paddr == ADDR_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end else if (wr_done && paddr == ADDR_MASK) begin
      mask_q <= pwdata[EV_W-1:0];
    end
  end

  // Sticky status and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RST;
      irq      <= 1'b0;
    end else begin
      status_q <= status_d;
      irq      <= |(status_q & mask_q);
    end
  end

  // Edge history of link clock, lock and mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d_q  <= 1'b0;
      lock_d_q <= 1'b0;
      bad_d_q  <= 1'b0;
    end else begin
      clk_d_q  <= clk_s;
      lock_d_q <= lock_s;
      bad_d_q  <= bad_mode;
    end
  end

  // Catch the word at each rising link edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= '0;
    end else if (rise_ev) begin
      cap_q <= word_s;
    end
  end

  // Enable period counters, measured in link periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      de_prev_q <= 1'b0;
      hi_per_q  <= 8'h00;
      lo_per_q  <= 8'hff;
    end else if (rise_ev) begin
      de_prev_q <= word_s.de;
      if (de_rise) begin
        hi_per_q <= 8'h01;
      end else if (de_fall) begin
        lo_per_q <= 8'h01;
      end else if (word_s.de) begin
        hi_per_q <= (hi_per_q == 8'hff) ? hi_per_q : hi_per_q + 8'h01;
      end else begin
        lo_per_q <= (lo_per_q == 8'hff) ? lo_per_q : lo_per_q + 8'h01;
      end
    end
  end

  // Enable high time in system cycles; stops one past the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cyc_q <= '0;
    end else if (!de_prev_q) begin
      hi_cyc_q <= '0;
    end else if (hi_cyc_q <= CNT_W'(DE_MAX_CYCLES)) begin
      hi_cyc_q <= hi_cyc_q + 1'b1;
    end
  end

  // Lock indicator, forced high in power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_unlocked_n <= 1'b1;
    end else begin
      link_unlocked_n <= ~(lock_s & pdn_s);
    end
  end

  // Output enable for data, sync, enable and clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_oe <= 1'b0;
    end else begin
      pix_oe <= ~off_q;
    end
  end

  // Recovered clock: follows link, parked in power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovered_clock_out <= 1'b0;
    end else if (pd_act) begin
      recovered_clock_out <= edge_s;
    end else if (rise_ev) begin
      recovered_clock_out <= 1'b1;
    end else if (fall_ev) begin
      recovered_clock_out <= 1'b0;
    end
  end

  // Parallel outputs launched on the chosen clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_data_out <= 18'h0;
      sync_bits_out  <= 3'h0;
      de_out         <= 1'b0;
    end else if (pd_act) begin
      pixel_data_out <= 18'h0;
      sync_bits_out  <= 3'h0;
      de_out         <= 1'b0;
    end else if (launch) begin
      pixel_data_out <= edge_s ? word_s.data : cap_q.data;
      sync_bits_out  <= edge_s ? word_s.sync : cap_q.sync;
      de_out         <= edge_s ? word_s.de : cap_q.de;
    end
  end

  // Checks
  property p_lock_out;
    @(posedge pclk) disable iff (!presetn)
      (lock_s && pdn_s) |=> !link_unlocked_n;
  endproperty
  a_lock_out: assert property (p_lock_out)
    else $error("lock output high while locked");

  property p_unlock_out;
    @(posedge pclk) disable iff (!presetn)
      !lock_s |=> link_unlocked_n;
  endproperty
  a_unlock_out: assert property (p_unlock_out)
    else $error("lock output low while unlocked");

  sequence s_pd_held;
    !pdn_s [*2];
  endsequence

  property p_pd_outputs;
    @(posedge pclk) disable iff (!presetn)
      s_pd_held |-> link_unlocked_n && pixel_data_out == 18'h0
                    && sync_bits_out == 3'h0 && !de_out;
  endproperty
  a_pd_outputs: assert property (p_pd_outputs)
    else $error("power-down outputs not forced");

  property p_pd_clock;
    @(posedge pclk) disable iff (!presetn)
      !pdn_s |=> recovered_clock_out == $past(edge_s);
  endproperty
  a_pd_clock: assert property (p_pd_clock)
    else $error("clock output not parked at edge level");

  property p_disable;
    @(posedge pclk) disable iff (!presetn)
      dis_s |=> !pix_oe;
  endproperty
  a_disable: assert property (p_disable)
    else $error("outputs driven while disabled");

  property p_enable;
    @(posedge pclk) disable iff (!presetn)
      (!dis_s && !ctrl_q[CTRL_SOFT_DIS]) |=> pix_oe;
  endproperty
  a_enable: assert property (p_enable)
    else $error("outputs floated while enabled");

  property p_rise_launch;
    @(posedge pclk) disable iff (!presetn)
      (rise_ev && edge_s && pdn_s) |=>
        pixel_data_out == $past(word_s.data) && recovered_clock_out;
  endproperty
  a_rise_launch: assert property (p_rise_launch)
    else $error("rising-edge launch wrong");

  property p_fall_hold;
    @(posedge pclk) disable iff (!presetn)
      (rise_ev && !edge_s && pdn_s) |=> $stable(pixel_data_out);
  endproperty
  a_fall_hold: assert property (p_fall_hold)
    else $error("data changed on rising edge in falling mode");

  property p_bad_mode;
    @(posedge pclk) disable iff (!presetn)
      $rose(bad_mode) |=> status_q[EV_BAD_MODE];
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("bad mode strap not flagged");

  property p_de_long;
    @(posedge pclk) disable iff (!presetn)
      (chk_on && !hs_mode && de_prev_q
       && hi_cyc_q == CNT_W'(DE_MAX_CYCLES)) |=> status_q[EV_HI_LONG];
  endproperty
  a_de_long: assert property (p_de_long)
    else $error("long enable not flagged");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (|(status_q & mask_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing");

endmodule : srx_output_ctrl

// >>> bench/srx_tx_model.sv
`timescale 1ns/1ps
// Link transmitter: sends whole enable cycles of pixel words on request
module srx_tx_model
  import srx_pkg::*;
(
  input  wire logic [7:0] hi_len,   // Enable high periods per cycle
  input  wire logic [7:0] lo_len,   // Enable low periods per cycle
  input  wire logic [7:0] goal,     // Cycle count to reach
  output logic            lclk,     // Link clock, 48 ns, frames only
  output srx_word_t       word,     // Pixel word
  output logic [7:0]      done_cnt  // Finished enable cycles
);
  int ph;  // Period within the enable cycle

  // One period per pass; the word changes at the falling edge
  initial begin
    lclk = 1'b0;
    word = '0;
    done_cnt = '0;
    ph = 0;
    forever begin
      if (ph == 0 && done_cnt == goal) begin
        word = ~word;  // Idle lines carry no stale word
        wait (done_cnt != goal);
      end
      word.de   = (ph < int'(hi_len));
      word.sync = ph[2:0];
      word.data = 18'(ph) ^ 18'h2a5a5;
      #24 lclk = 1'b1;
      #24 lclk = 1'b0;
      ph = ph + 1;
      // Stop only after a whole low run
      if (ph == int'(hi_len) + int'(lo_len)) begin
        ph = 0;
        done_cnt = done_cnt + 8'h01;
      end
    end
  end
endmodule : srx_tx_model

// >>> bench/test_srx_output_ctrl.sv
`timescale 1ns/1ps
// Register and pin level checks of the output controller
module test_srx_output_ctrl;
  import srx_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic        pready, pslverr, er, lclk, pll_locked, power_down_n;
  logic        output_disable, edge_select, pix_oe, link_unlocked_n;
  logic        irq, recovered_clock_out, de_out;
  logic [1:0]  op_mode_select;
  logic [17:0] pixel_data_out;
  logic [2:0]  sync_bits_out;
  logic [7:0]  done_cnt;
  logic [7:0]  hi_len = 8'h00;  // Set before the link model first looks
  logic [7:0]  lo_len = 8'h00;
  logic [7:0]  goal   = 8'h00;
  logic [21:0] outw;   // Output word in link word layout
  srx_word_t   word;
  int          bad_count, check_count;

  assign outw = {de_out, sync_bits_out, pixel_data_out};

  srx_output_ctrl #(.DE_MAX_CYCLES(200), .CNT_W(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk_in(lclk),
    .link_word_in(word), .pll_locked(pll_locked),
    .power_down_n(power_down_n), .output_disable(output_disable),
    .edge_select(edge_select), .op_mode_select(op_mode_select),
    .pixel_data_out(pixel_data_out), .sync_bits_out(sync_bits_out),
    .de_out(de_out), .recovered_clock_out(recovered_clock_out),
    .pix_oe(pix_oe), .link_unlocked_n(link_unlocked_n), .irq(irq));

  srx_tx_model tx_u (.hi_len(hi_len), .lo_len(lo_len), .goal(goal),
    .lclk(lclk), .word(word), .done_cnt(done_cnt));

  // Verdict and end of run
  task automatic close_out();
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // Compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);  // One idle edge before any next setup
    if (n >= 50) begin
      bad_count++;
      close_out();
    end
  endtask : apb

  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(d, e);
  endtask : rdx

  // Start n enable cycles on the link
  task automatic go(input logic [7:0] h, input logic [7:0] l,
                    input logic [7:0] n);
    hi_len <= h;
    lo_len <= l;
    goal <= done_cnt + n;
  endtask : go

  // Wait, bounded, for the link to go idle
  task automatic fin();
    int n;
    n = 0;
    tick(1);
    while (done_cnt !== goal && n < 20000) begin
      tick(1);
      n++;
    end
    if (n >= 20000) begin
      bad_count++;
      close_out();
    end
  endtask : fin

  // Launch edge follows edge select
  task automatic edge_chk(input logic es);
    srx_word_t p, w;
    edge_select <= es;
    tick(6);
    go(8'h04, 8'h3c, 8'h01);
    @(posedge lclk);
    p = word;
    @(posedge lclk);
    w = word;
    tick(5);
    chk(32'(recovered_clock_out), 32'h1);
    chk(32'(outw), es ? 32'(w) : 32'(p));
    @(negedge lclk);
    tick(5);
    chk(32'(recovered_clock_out), 32'h0);
    chk(32'(outw), 32'(w));
    fin();
  endtask : edge_chk

  // System clock, 4 ns
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    close_out();
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pll_locked, output_disable, op_mode_select} = '0;
    {power_down_n, edge_select} = 2'h3;
    tick(3);
    chk(32'(link_unlocked_n), 32'h1);
    presetn <= 1'b1;
    rdx(ADDR_CTRL, 32'h2);
    rdx(ADDR_MASK, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({d[30:0], er}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h3f);
    rdx(ADDR_MASK, 32'h3f);
    apb(1'b1, ADDR_MASK, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hff);
    rdx(ADDR_STATUS, 32'h0);
    chk(32'(link_unlocked_n), 32'h1);
    pll_locked <= 1'b1;
    tick(6);
    chk(32'(link_unlocked_n), 32'h0);
    chk(32'(pix_oe), 32'h1);
    rdx(ADDR_STATUS, 32'h2);
    edge_chk(1'b1);
    edge_chk(1'b0);
    rdx(ADDR_STATUS, 32'h0);
    edge_select <= 1'b1;
    go(8'h01, 8'h3c, 8'h02);
    fin();
    rdx(ADDR_STATUS, 32'h4);
    chk(32'(irq), 32'h0);
    apb(1'b1, ADDR_MASK, 32'h10);
    go(8'h1e, 8'h0a, 8'h02);
    fin();
    chk(32'(irq), 32'h1);
    rdx(ADDR_STATUS, 32'h18);
    tick(3);
    chk(32'(irq), 32'h0);
    op_mode_select <= MODE_HANDSHAKE;
    tick(5);
    go(8'h02, 8'h02, 8'h03);
    fin();
    rdx(ADDR_STATUS, 32'h0);
    // Every strap code, then the unsupported-code event
    for (int m = 0; m < 4; m++) begin
      op_mode_select <= 2'(m);
      tick(5);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk(d & 32'h3e, 32'({2'(m), 4'ha}));
    end
    rdx(ADDR_STATUS, 32'h20);
    op_mode_select <= MODE_NORMAL;
    pll_locked <= 1'b0;
    tick(6);
    chk(32'(link_unlocked_n), 32'h1);
    rdx(ADDR_STATUS, 32'h1);
    pll_locked <= 1'b1;
    tick(6);
    // Power-down and output-disable combinations
    for (int e = 0; e < 2; e++) begin
      edge_select <= 1'(e);
      power_down_n <= 1'b0;
      tick(6);
      chk(32'(outw), 32'h0);
      chk(32'(link_unlocked_n), 32'h1);
      chk(32'(recovered_clock_out), 32'(e));
      chk(32'(pix_oe), 32'h1);
      output_disable <= 1'b1;
      tick(5);
      chk(32'(pix_oe), 32'h0);
      power_down_n <= 1'b1;
      tick(5);
      chk(32'(pix_oe), 32'h0);
      output_disable <= 1'b0;
      tick(5);
      chk(32'(pix_oe), 32'h1);
    end
    apb(1'b1, ADDR_CTRL, 32'h3);
    tick(3);
    chk(32'(pix_oe), 32'h0);
    close_out();
  end
endmodule : test_srx_output_ctrl
